// ### hw/dscps_core.sv
// Programmer-visible state of the signal controller core.
`timescale 1ns/1ps
`include "dscps_params.svh"
module dscps_core (
  // Clock and reset.
  input  wire  logic                  clk_sys,
  input  wire  logic                  rstn,
  // Program fetch port.
  output logic [22:0]                 prog_addr,
  input  wire  logic [23:0]           prog_rdata,
  output logic [23:0]                 instr_word,
  output logic                        instr_valid,
  input  wire  logic                  pc_load,
  input  wire  logic [22:0]           pc_target,
  input  wire  logic                  special_mode,
  // Register port.
  input  wire  dscps_pkg::dscps_wr_t  reg_wr,
  input  wire  logic [4:0]            rd_a_idx,
  input  wire  logic [4:0]            rd_b_idx,
  output logic [15:0]                 rd_a_data,
  output logic [15:0]                 rd_b_data,
  input  wire  dscps_pkg::dscps_flag_t flag_upd,
  // Stack, shadow and loop events.
  input  wire  logic                  call_push,
  input  wire  logic                  ret_pop,
  input  wire  logic                  shadow_push,
  input  wire  logic                  shadow_pop,
  input  wire  logic                  loop_begin,
  input  wire  logic                  loop_finish,
  input  wire  logic [22:0]           loop_start_in,
  input  wire  logic [22:0]           loop_end_in,
  input  wire  logic [13:0]           loop_count_in,
  output dscps_pkg::dscps_stack_t     stack_wr,
  // Exceptions.
  input  wire  logic [7:0]            trap_req,
  input  wire  logic [53:0]           irq_req,
  input  wire  logic [161:0]          irq_prio,
  output logic                        exc_take,
  output logic [5:0]                  exc_vector,
  // Program space view and table access.
  input  wire  logic                  view_rd,
  input  wire  logic                  tbl_rd,
  input  wire  logic [15:0]           data_addr,
  output logic [22:0]                 pd_addr,
  input  wire  logic [23:0]           pd_rdata,
  output logic [23:0]                 pd_data,
  output logic                        pd_valid,
  output logic                        view_stall,
  // Dual data fetch.
  input  wire  logic                  mac_op,
  input  wire  logic [3:0]            x_ptr_idx,
  input  wire  logic [3:0]            y_ptr_idx,
  output logic [15:0]                 x_addr,
  output logic [15:0]                 y_addr,
  output logic                        y_en,
  output logic                        y_range_err,
  // Shifter.
  input  wire  logic [39:0]           shift_in,
  input  wire  logic signed [5:0]     shift_amt,
  output logic [39:0]                 shift_out
);
  import dscps_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State.
  logic [15:0] w_reg [16];
  logic [15:0] w_next [16];
  logic [15:0] shw_reg [4];
  logic [15:0] shw_next [4];
  logic [15:0] sr_reg, sr_next, shsr_reg, shsr_next;
  logic [7:0]  program_space_view_page_reg, program_space_view_page_next, table_page_reg, table_page_next;
  logic [22:0] lstart_reg, lstart_next, lend_reg, lend_next;
  logic [13:0] lcount_reg, lcount_next;
  logic [22:0] shls_reg, shls_next, shle_reg, shle_next;
  logic [13:0] shlc_reg, shlc_next;
  logic [22:0] pc_reg, pc_next;
  logic [23:0] iw_reg, iw_next;
  logic        iv_reg, iv_next;
  dscps_exc_t  exc_reg, exc_next;
  logic [22:0] exc_pc_reg, exc_pc_next;
  logic [2:0]  exc_pr_ipl_reg, exc_pr_ipl_next;
  dscps_stack_t stk_reg, stk_next;
  logic        view_wait_reg, view_wait_next;
  logic [23:0] pd_reg, pd_next;
  logic        pdv_reg, pdv_next;
  logic [39:0] sh_reg, sh_next;

  //////////////////////////////////////////////////////////////////////////////
  // Exception arbitration.
  logic [3:0] best_prio;
  logic [5:0] best_vec;
  logic       best_hit;
  logic [2:0] ipl;
  localparam logic [7:0] trap_rsvd_mask = `DSCPS_TRAP_RSVD;
  assign ipl = sr_reg[`DSCPS_SR_IPL_LO +: 3];

  always_comb begin
    best_prio = {1'b0, ipl};
    best_vec  = 6'h00;
    best_hit  = 1'b0;
    // Lower index wins ties because only a strictly higher level replaces.
    for (int i = 0; i < `DSCPS_N_IRQS; i++) begin
      if (irq_req[i] && irq_prio[3*i +: 3] != 3'h0 && {1'b0, irq_prio[3*i +: 3]} > best_prio) begin // RULE14
        best_prio = {1'b0, irq_prio[3*i +: 3]};
        best_vec  = 6'(i + `DSCPS_N_TRAPS);
        best_hit  = 1'b1;
      end
    end
    for (int t = 0; t < `DSCPS_N_TRAPS; t++) begin
      if (trap_req[t] && !trap_rsvd_mask[t] && 4'(t + 8) >= best_prio) begin // RULE15
        best_prio = 4'(t + 8);
        best_vec  = 6'(t); // RULE13
        best_hit  = 1'b1;
      end
    end
  end

  assign exc_take   = best_hit && exc_reg == DSCPS_IDLE;
  assign exc_vector = best_vec;

  //////////////////////////////////////////////////////////////////////////////
  // Fetch, stack and register next state.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      w_next[i] = w_reg[i];
    end
    for (int i = 0; i < 4; i++) begin
      shw_next[i] = shw_reg[i];
    end
    sr_next        = sr_reg;
    shsr_next      = shsr_reg;
    program_space_view_page_next    = program_space_view_page_reg;
    table_page_next    = table_page_reg;
    lstart_next    = lstart_reg;
    lend_next      = lend_reg;
    lcount_next    = lcount_reg;
    shls_next      = shls_reg;
    shle_next      = shle_reg;
    shlc_next      = shlc_reg;
    pc_next        = pc_reg;
    iw_next        = prog_rdata; // RULE21
    iv_next        = 1'b1;
    exc_next       = exc_reg;
    exc_pc_next    = exc_pc_reg;
    exc_pr_ipl_next = exc_pr_ipl_reg;
    stk_next       = '0;
    // Register port; shadows have no index.
    if (reg_wr.we) begin // RULE10
      if (reg_wr.idx[4] == 1'b0) begin
        if (reg_wr.byte_op) begin
          w_next[reg_wr.idx[3:0]][7:0] = reg_wr.data[7:0]; // RULE7
        end else begin
          w_next[reg_wr.idx[3:0]] = reg_wr.data; // RULE3
        end
      end else begin
        case (reg_wr.idx)
          `DSCPS_IDX_SR:     sr_next = reg_wr.byte_op ? {sr_reg[15:8], reg_wr.data[7:0]} : reg_wr.data; // RULE11
          `DSCPS_IDX_PROGRAM_SPACE_VIEW_PAGE: program_space_view_page_next = reg_wr.data[7:0];
          `DSCPS_IDX_TABLE_PAGE: table_page_next = reg_wr.data[7:0];
          `DSCPS_IDX_LSTART: lstart_next = {7'h00, reg_wr.data[15:1], 1'b0};
          `DSCPS_IDX_LEND:   lend_next = {7'h00, reg_wr.data[15:1], 1'b0};
          `DSCPS_IDX_LCOUNT: lcount_next = reg_wr.data[13:0];
          default: ;
        endcase
      end
    end
    if (flag_upd.we) begin
      sr_next = (sr_next & ~flag_upd.mask) | (flag_upd.value & flag_upd.mask);
    end
    // Whole shadow sets move in one cycle.
    if (shadow_push) begin // RULE23
      for (int i = 0; i < 4; i++) begin
        shw_next[i] = w_reg[i]; // RULE8
      end
      shsr_next = sr_reg & `DSCPS_SR_SHADOW;
    end else if (shadow_pop) begin // RULE23
      for (int i = 0; i < 4; i++) begin
        w_next[i] = shw_reg[i]; // RULE8
      end
      sr_next = (sr_next & ~`DSCPS_SR_SHADOW) | (shsr_reg & `DSCPS_SR_SHADOW);
    end
    if (loop_begin) begin // RULE9
      shls_next   = lstart_reg;
      shle_next   = lend_reg;
      shlc_next   = lcount_reg;
      lstart_next = {loop_start_in[22:1], 1'b0};
      lend_next   = {loop_end_in[22:1], 1'b0};
      lcount_next = loop_count_in;
      sr_next[`DSCPS_SR_DA] = 1'b1;
    end else if (loop_finish) begin // RULE9
      lstart_next = shls_reg;
      lend_next   = shle_reg;
      lcount_next = shlc_reg;
      sr_next[`DSCPS_SR_DA] = 1'b0;
    end
    // Program counter advance with prefetch flush on a jump.
    if (pc_load) begin
      pc_next = {pc_target[22:1], 1'b0};
      iv_next = 1'b0;
    end else if (!view_stall) begin
      pc_next = pc_reg + `DSCPS_PC_STEP;
    end else begin
      iw_next = iw_reg;
      iv_next = iv_reg;
    end
    // Call and return move the stack pointer by one return address.
    if (call_push) begin // RULE4
      w_next[15] = w_next[15] + 16'h0004;
    end else if (ret_pop) begin // RULE4
      w_next[15] = w_next[15] - 16'h0004;
    end
    // Exception entry stacks the counter over two cycles.
    case (exc_reg)
      DSCPS_IDLE: begin
        if (exc_take) begin
          exc_next    = DSCPS_PUSH_LO;
          exc_pc_next = pc_reg;
          exc_pr_ipl_next = ipl;
          pc_next     = `DSCPS_VEC_BASE + {16'h0000, best_vec, 1'b0};
          iv_next     = 1'b0;
          sr_next[`DSCPS_SR_IPL_LO +: 3] = best_prio[3] ? 3'h7 : best_prio[2:0];
        end
      end
      DSCPS_PUSH_LO: begin
        stk_next   = '{we: 1'b1, addr: w_reg[15], data: exc_pc_reg[15:0]};
        w_next[15] = w_reg[15] + 16'h0002; // RULE4
        exc_next   = DSCPS_PUSH_HI;
      end
      DSCPS_PUSH_HI: begin
        // Stacked word keeps the level held before entry.
        stk_next   = '{we: 1'b1, addr: w_reg[15],
                       data: {(sr_reg[7:0] & 8'h1f) | {exc_pr_ipl_reg, 5'h00}, 1'b0, exc_pc_reg[22:16]}}; // RULE12
        w_next[15] = w_reg[15] + 16'h0002;
        exc_next   = DSCPS_IDLE;
      end
      default: exc_next = DSCPS_IDLE;
    endcase
    w_next[15][0] = 1'b0; // RULE5
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program view window and table reads on the data-side program port.
  always_comb begin
    pd_addr        = {table_page_reg[6:0], data_addr}; // RULE18
    view_wait_next = 1'b0;
    pd_next        = pd_reg;
    pdv_next       = 1'b0;
    view_stall     = 1'b0;
    if (view_rd && data_addr[`DSCPS_PSV_BIT]) begin
      pd_addr    = {program_space_view_page_reg, data_addr[14:0]}; // RULE16
      view_stall = !view_wait_reg; // RULE17
      view_wait_next = !view_wait_reg;
      if (view_wait_reg) begin
        pd_next  = {8'h00, pd_rdata[15:0]}; // RULE17
        pdv_next = 1'b1;
      end
    end else if (tbl_rd) begin
      pd_next  = pd_rdata; // RULE18
      pdv_next = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Single-cycle shifter: positive amounts shift right, negative left.
  always_comb begin
    sh_next = shift_in;
    if (shift_amt >= 6'sd0) begin
      sh_next = $signed(shift_in) >>> (shift_amt > 6'sd15 ? 6'd15 : shift_amt); // RULE20
    end else begin
      sh_next = shift_in << (shift_amt < -6'sd16 ? 6'd16 : 6'(-shift_amt)); // RULE20
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        w_reg[i] <= 16'h0000;
      end
      w_reg[15] <= `DSCPS_SP_RESET; // RULE6
      for (int i = 0; i < 4; i++) begin
        shw_reg[i] <= 16'h0000;
      end
      sr_reg        <= 16'h0000;
      shsr_reg      <= 16'h0000;
      program_space_view_page_reg    <= 8'h00;
      table_page_reg    <= 8'h00;
      lstart_reg    <= 23'h000000;
      lend_reg      <= 23'h000000;
      lcount_reg    <= 14'h0000;
      shls_reg      <= 23'h000000;
      shle_reg      <= 23'h000000;
      shlc_reg      <= 14'h0000;
      pc_reg        <= 23'h000000;
      iw_reg        <= 24'h000000;
      iv_reg        <= 1'b0;
      exc_reg       <= DSCPS_IDLE;
      exc_pc_reg    <= 23'h000000;
      exc_pr_ipl_reg <= 3'h0;
      stk_reg       <= '0;
      view_wait_reg <= 1'b0;
      pd_reg        <= 24'h000000;
      pdv_reg       <= 1'b0;
      sh_reg        <= 40'h0000000000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        w_reg[i] <= w_next[i];
      end
      for (int i = 0; i < 4; i++) begin
        shw_reg[i] <= shw_next[i];
      end
      sr_reg        <= sr_next;
      shsr_reg      <= shsr_next;
      program_space_view_page_reg    <= program_space_view_page_next;
      table_page_reg    <= table_page_next;
      lstart_reg    <= lstart_next;
      lend_reg      <= lend_next;
      lcount_reg    <= lcount_next;
      shls_reg      <= shls_next;
      shle_reg      <= shle_next;
      shlc_reg      <= shlc_next;
      pc_reg        <= {pc_next[22:1], 1'b0}; // RULE1
      iw_reg        <= iw_next;
      iv_reg        <= iv_next;
      exc_reg       <= exc_next;
      exc_pc_reg    <= exc_pc_next;
      exc_pr_ipl_reg <= exc_pr_ipl_next;
      stk_reg       <= stk_next;
      view_wait_reg <= view_wait_next;
      pd_reg        <= pd_next;
      pdv_reg       <= pdv_next;
      sh_reg        <= sh_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.
  function automatic logic [15:0] rd_mux(input logic [4:0] idx);
    case (idx)
      `DSCPS_IDX_SR:     rd_mux = sr_reg;
      `DSCPS_IDX_PROGRAM_SPACE_VIEW_PAGE: rd_mux = {8'h00, program_space_view_page_reg};
      `DSCPS_IDX_TABLE_PAGE: rd_mux = {8'h00, table_page_reg};
      `DSCPS_IDX_LSTART: rd_mux = lstart_reg[15:0];
      `DSCPS_IDX_LEND:   rd_mux = lend_reg[15:0];
      `DSCPS_IDX_LCOUNT: rd_mux = {2'b00, lcount_reg};
      default:           rd_mux = idx[4] ? 16'h0000 : w_reg[idx[3:0]];
    endcase
  endfunction

  // Two read ports, a data port and a program port serve one cycle together.
  // Procedural reads so a register update shows even while the index stands still.
  always_comb begin
    rd_a_data = rd_mux(rd_a_idx); // RULE22
    rd_b_data = rd_mux(rd_b_idx); // RULE22
  end
  assign prog_addr   = {special_mode & pc_reg[22], pc_reg[21:1], 1'b0}; // RULE2
  assign instr_word  = iw_reg;
  assign instr_valid = iv_reg;
  assign stack_wr    = stk_reg;
  assign pd_data     = pd_reg;
  assign pd_valid    = pdv_reg;
  assign shift_out   = sh_reg;
  assign x_addr      = w_reg[x_ptr_idx];
  assign y_addr      = w_reg[y_ptr_idx];
  assign y_en        = mac_op; // RULE19
  assign y_range_err = mac_op && (w_reg[y_ptr_idx] < `DSCPS_XY_BOUNDARY ||
                                  w_reg[x_ptr_idx] >= `DSCPS_XY_BOUNDARY); // RULE19

endmodule // dscps_core

// ### hw/dscps_params.svh
// Constants of the core programmer-state block.
// Overview of operation
// RULE1: 24-bit instruction words, 23-bit program counter, bit zero always clear.
// RULE2: Counter top bit ignored except in the specialised access mode.
// RULE3: Sixteen 16-bit working registers, all reachable through the register port.
// RULE4: Stack pointer moves on exceptions, calls and returns, yet stays writable.
// RULE5: Stack pointer bit zero always reads and stores as zero.
// RULE6: Stack pointer resets to 0x0800.
// RULE7: Byte writes to a working register change only its low byte.
// RULE8: Shadow push/pop moves registers zero to three and five status flags.
// RULE9: Loop start, end and count shadowed on loop begin, restored on end.
// RULE10: Shadow registers have no software read or write path.
// RULE11: 16-bit status word with flags, priority level, repeat and loop bits.
// RULE12: Exception entry stacks low status byte joined with upper counter byte.
// RULE13: Sixty-two vectors: eight traps, four reserved, and fifty-four interrupts.
// RULE14: Interrupt priority 1 to 7, ties broken by fixed natural order.
// RULE15: Traps take fixed priorities 8 to 15, above every interrupt.
// RULE16: Upper data half maps to program space via 8-bit view page.
// RULE17: View window returns low 16 bits and costs one extra cycle.
// RULE18: Table access reaches all 24 bits through table-page selected pages.
// RULE19: Data space split into X and Y; multiply class fetches both.
// RULE20: Shift right up to 15 or left up to 16 in one cycle.
// RULE21: Only single-stage prefetch, fetched one cycle before execution.
// RULE22: Per cycle: data read, register read, data write, program read.
// RULE23: Each shadow transfer completes in one cycle, never partially.
`ifndef DSCPS_PARAMS_SVH
`define DSCPS_PARAMS_SVH
`define DSCPS_SP_RESET      16'h0800
`define DSCPS_PC_STEP       23'h000002
`define DSCPS_VEC_BASE      23'h000004
`define DSCPS_XY_BOUNDARY   16'h0c00
`define DSCPS_PSV_BIT       15
`define DSCPS_IDX_SR        5'h10
`define DSCPS_IDX_PROGRAM_SPACE_VIEW_PAGE    5'h11
`define DSCPS_IDX_TABLE_PAGE    5'h12
`define DSCPS_IDX_LSTART    5'h13
`define DSCPS_IDX_LEND      5'h14
`define DSCPS_IDX_LCOUNT    5'h15
`define DSCPS_SR_C          0
`define DSCPS_SR_Z          1
`define DSCPS_SR_OV         2
`define DSCPS_SR_N          3
`define DSCPS_SR_RA         4
`define DSCPS_SR_IPL_LO     5
`define DSCPS_SR_DC         8
`define DSCPS_SR_DA         9
`define DSCPS_SR_SHADOW     16'h010f
`define DSCPS_N_TRAPS       8
`define DSCPS_N_IRQS        54
`define DSCPS_TRAP_RSVD     8'h0f
`endif

// ### hw/dscps_pkg.sv
// Types shared by the core programmer-state block.
package dscps_pkg;
  typedef struct packed {
    logic        we;
    logic        byte_op;
    logic [4:0]  idx;
    logic [15:0] data;
  } dscps_wr_t;
  typedef struct packed {
    logic        we;
    logic [15:0] mask;
    logic [15:0] value;
  } dscps_flag_t;
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } dscps_stack_t;
  typedef enum logic [1:0] {DSCPS_IDLE, DSCPS_PUSH_LO, DSCPS_PUSH_HI} dscps_exc_t;
endpackage

// ### verif/dscps_core_monitor.sv
// Concurrent checks on the ports of the core programmer-state block.
`timescale 1ns/1ps
module dscps_core_monitor (
  // Clock and reset.
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  // Fetch and register ports.
  input wire logic [22:0]            prog_addr,
  input wire logic [23:0]            prog_rdata,
  input wire logic [23:0]            instr_word,
  input wire logic                   pc_load,
  input wire logic                   special_mode,
  input wire logic [4:0]             rd_a_idx,
  input wire logic [15:0]            rd_a_data,
  // Exceptions and stack.
  input wire dscps_pkg::dscps_stack_t stack_wr,
  input wire logic [7:0]             trap_req,
  input wire logic [53:0]            irq_req,
  input wire logic                   exc_take,
  input wire logic [5:0]             exc_vector,
  // Program data, dual fetch and shifter.
  input wire logic                   view_rd,
  input wire logic                   tbl_rd,
  input wire logic [15:0]            data_addr,
  input wire logic [22:0]            pd_addr,
  input wire logic [23:0]            pd_rdata,
  input wire logic [23:0]            pd_data,
  input wire logic                   pd_valid,
  input wire logic                   view_stall,
  input wire logic                   mac_op,
  input wire logic                   y_en,
  input wire logic [39:0]            shift_in,
  input wire logic signed [5:0]      shift_amt,
  input wire logic [39:0]            shift_out
);
  import dscps_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  a_sp_after_reset: assert property ($rose(rstn) && rd_a_idx == 5'h0f |-> rd_a_data == 16'h0800)
    else $error("stack pointer not at its reset value");
  a_sp_bit0_clear: assert property (rd_a_idx == 5'h0f |-> !rd_a_data[0])
    else $error("stack pointer bit zero set");
  a_pc_bits_clear: assert property (!prog_addr[0] && (special_mode || !prog_addr[22]))
    else $error("fetch address bit zero or top bit set");
  a_prefetch_step: assert property (!pc_load && !view_stall && !exc_take && !special_mode |=>
    instr_word == $past(prog_rdata) && prog_addr[21:0] == $past(prog_addr[21:0]) + 22'h2)
    else $error("prefetch did not follow the fetch address");
  a_exc_entry_pc: assert property (exc_take && !pc_load |=>
    prog_addr == 23'h000004 + {16'h0, $past(exc_vector), 1'b0})
    else $error("exception did not jump to its vector");
  a_exc_two_pushes: assert property (exc_take |-> ##[1:3] stack_wr.we ##1 stack_wr.we)
    else $error("exception entry did not stack two words");
  a_exc_hi_word: assert property (stack_wr.we && $past(stack_wr.we) |->
    !stack_wr.data[7] && stack_wr.addr == $past(stack_wr.addr) + 16'h2)
    else $error("second stacked word misplaced or malformed");
  a_trap_beats_irq: assert property (exc_take && trap_req[7:4] != 4'h0 |->
    exc_vector < 6'd8 && trap_req[exc_vector[2:0]])
    else $error("interrupt taken over a pending trap");
  a_rsvd_trap_ignored: assert property (irq_req == 54'h0 && trap_req[7:4] == 4'h0 |-> !exc_take)
    else $error("reserved trap accepted");
  a_view_timing: assert property (view_rd && data_addr[15] && !$past(view_rd) |->
    view_stall ##2 pd_valid && pd_data[23:16] == 8'h00)
    else $error("view read timing or width wrong");
  a_table_word: assert property (tbl_rd |-> pd_addr[15:0] == data_addr ##1 pd_data == $past(pd_rdata))
    else $error("table read lost part of the word");
  a_single_x_fetch: assert property (!mac_op |-> !y_en)
    else $error("second fetch outside multiply class");
  a_shift_left_max: assert property (shift_amt == -6'sd16 |=> shift_out == {$past(shift_in[23:0]), 16'h0})
    else $error("left shift by sixteen wrong");
  c_exception: cover property (exc_take);
  c_view_read: cover property (pd_valid);
  c_stack_push: cover property (stack_wr.we);
endmodule // dscps_core_monitor

bind dscps_core dscps_core_monitor u_mon (.clk_sys, .rstn, .prog_addr, .prog_rdata, .instr_word, .pc_load,
  .special_mode, .rd_a_idx, .rd_a_data, .stack_wr, .trap_req, .irq_req, .exc_take, .exc_vector, .view_rd,
  .tbl_rd, .data_addr, .pd_addr, .pd_rdata, .pd_data, .pd_valid, .view_stall, .mac_op, .y_en, .shift_in,
  .shift_amt, .shift_out);

// ### verif/dscps_mem_model.sv
// Combinational program memory behind the fetch and program data ports.
`timescale 1ns/1ps
module dscps_mem_model (
  // Fetch side.
  input  wire logic [22:0] prog_addr,
  output logic      [23:0] prog_rdata,
  // Program data side.
  input  wire logic [22:0] pd_addr,
  output logic      [23:0] pd_rdata
);
  // Every word uses all 24 bits so a lost upper byte shows.
  assign prog_rdata = {prog_addr[7:0] ^ 8'ha5, prog_addr[15:0]};
  assign pd_rdata   = {pd_addr[22:15], pd_addr[15:0] ^ 16'h3c3c};
endmodule // dscps_mem_model

// ### verif/dsc_core_programmer_state_tb_top.sv
// Self-checking bench for the core programmer-state block.
`timescale 1ns/1ps
module dsc_core_programmer_state_tb_top;
  import dscps_pkg::*;
  typedef struct packed {logic bop; logic [4:0] idx; logic [15:0] data; logic [15:0] exp;} dscps_row_t;
  logic               clk_sys = 1'b0;
  logic               rstn = 1'b0;
  logic [22:0]        prog_addr, pd_addr, pc_target = '0;
  logic [23:0]        prog_rdata, instr_word, pd_rdata, pd_data;
  logic [15:0]        rd_a_data, rd_b_data, x_addr, y_addr, data_addr = '0;
  logic [4:0]         rd_a_idx = 5'h0f;
  logic [3:0]         x_ptr_idx = 4'h8, y_ptr_idx = 4'ha;
  logic               pc_load = 0, special_mode = 0, call_push = 0, ret_pop = 0, shadow_push = 0;
  logic               shadow_pop = 0, loop_begin = 0, loop_finish = 0, view_rd = 0, tbl_rd = 0, mac_op = 0;
  logic               exc_take, pd_valid, view_stall, y_en, y_range_err, instr_valid;
  logic [7:0]         trap_req = '0;
  logic [53:0]        irq_req = '0;
  logic [161:0]       irq_prio = '0;
  logic [5:0]         exc_vector;
  logic [39:0]        shift_in = '0, shift_out;
  logic signed [5:0]  shift_amt = '0;
  dscps_wr_t          reg_wr = '0;
  dscps_flag_t        flag_upd = '0;
  int                 bad_count = 0, checks = 0, cycles = 0, n;
  dscps_row_t         rows[7] = '{'{0, 5'h03, 16'ha5c3, 16'ha5c3}, '{1, 5'h03, 16'h1177, 16'ha577},
    '{0, 5'h0e, 16'hbeef, 16'hbeef}, '{0, 5'h0f, 16'h1235, 16'h1234}, '{0, 5'h11, 16'h0003, 16'h0003},
    '{0, 5'h12, 16'h0005, 16'h0005}, '{0, 5'h16, 16'hffff, 16'h0000}};
  dscps_core u_dut (.clk_sys, .rstn, .prog_addr, .prog_rdata, .instr_word, .instr_valid, .pc_load,
    .pc_target, .special_mode, .reg_wr, .rd_a_idx, .rd_b_idx(5'h00), .rd_a_data, .rd_b_data, .flag_upd,
    .call_push, .ret_pop, .shadow_push, .shadow_pop, .loop_begin, .loop_finish, .loop_start_in(23'h000100),
    .loop_end_in(23'h000180), .loop_count_in(14'h0005), .stack_wr(), .trap_req, .irq_req, .irq_prio,
    .exc_take, .exc_vector, .view_rd, .tbl_rd, .data_addr, .pd_addr, .pd_rdata, .pd_data, .pd_valid,
    .view_stall, .mac_op, .x_ptr_idx, .y_ptr_idx, .x_addr, .y_addr, .y_en, .y_range_err, .shift_in,
    .shift_amt, .shift_out);
  dscps_mem_model u_mem (.prog_addr, .prog_rdata, .pd_addr, .pd_rdata);
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] pd_word(logic [22:0] a);
    return {a[22:15], a[15:0] ^ 16'h3c3c};
  endfunction
  task automatic step(int k = 1);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask
  task automatic check(logic [39:0] seen, logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic bop, logic [4:0] idx, logic [15:0] data);
    reg_wr = '{1'b1, bop, idx, data};
    step();
    reg_wr.we = 1'b0;
    step();
  endtask
  task automatic rd(logic [4:0] idx);
    rd_a_idx = idx;
    #1;
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    step();
    sig = 1'b0;
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    irq_prio[17:15] = 3'd3;
    step(16);
    rstn = 1'b1;
    rd(5'h0f); check(rd_a_data, 16'h0800);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].bop, rows[i].idx, rows[i].data);
      rd(rows[i].idx); check(rd_a_data, rows[i].exp);
    end
    pulse(call_push);
    rd(5'h0f); check(rd_a_data, 16'h1238);
    pulse(ret_pop);
    rd(5'h0f); check(rd_a_data, 16'h1234);
    wr(0, 5'h00, 16'h1111);
    wr(0, 5'h10, 16'h03ff);
    pulse(shadow_push);
    wr(0, 5'h00, 16'h0000);
    wr(0, 5'h10, 16'h0000);
    pulse(shadow_pop);
    rd(5'h00); check(rd_a_data, 16'h1111);
    check(rd_b_data, 16'h1111);
    rd(5'h10); check(rd_a_data, 16'h010f);
    pulse(loop_begin);
    rd(5'h10); check(rd_a_data & 16'h0200, 16'h0200);
    pulse(loop_finish);
    rd(5'h10); check(rd_a_data & 16'h0200, 16'h0000);
    flag_upd = '{1'b1, 16'h0003, 16'h0001};
    step();
    flag_upd.we = 1'b0;
    rd(5'h10);
    check(rd_a_data & 16'h0003, 16'h0001);
    irq_req[5] = 1'b1;
    #1; check({exc_take, exc_vector}, {1'b1, 6'd13});
    step();
    irq_req = '0;
    step(4);
    rd(5'h0f); check(rd_a_data, 16'h1238);
    rd(5'h10); check(rd_a_data & 16'h00e0, 16'h0060);
    irq_prio[17:15] = 3'd5;
    irq_prio[29:27] = 3'd5;
    irq_prio[8:6] = 3'd4;
    irq_req = 54'h0000000000224;
    #1; check(exc_vector, 6'd13);
    step();
    irq_req = '0;
    step(4);
    trap_req = 8'h0f;
    #1; check(exc_take, 1'b0);
    step();
    trap_req = 8'h30;
    irq_req[5] = 1'b1;
    #1; check(exc_vector, 6'd5);
    step();
    trap_req = '0;
    irq_req = '0;
    step(4);
    data_addr = 16'h8010;
    view_rd = 1'b1;
    #1; check({view_stall, pd_addr}, {1'b1, 8'h03, 15'h0010});
    step(2);
    view_rd = 1'b0;
    n = 0;
    while (pd_valid !== 1'b1 && n < 4) begin
      step();
      n++;
    end
    check(pd_data, pd_word({8'h03, 15'h0010}) & 24'h00ffff);
    data_addr = 16'h1234;
    tbl_rd = 1'b1;
    #1; check(pd_addr, {7'h05, 16'h1234});
    step();
    tbl_rd = 1'b0;
    check(pd_data, pd_word({7'h05, 16'h1234}));
    wr(0, 5'h0a, 16'h0c40);
    mac_op = 1'b1;
    #1; check({y_en, y_range_err, y_addr, x_addr}, {1'b1, 1'b0, 16'h0c40, 16'h0000});
    x_ptr_idx = 4'ha;
    #1;
    check(y_range_err, 1'b1);
    step();
    mac_op = 1'b0;
    shift_in = 40'h8000000001;
    shift_amt = 6'sd15;
    step();
    check(shift_out, 40'hffff000000);
    shift_amt = -6'sd16;
    step();
    check(shift_out, {shift_in[23:0], 16'h0});
    pc_target = 23'h400100;
    pc_load = 1'b1;
    step();
    pc_load = 1'b0;
    check(prog_addr, 23'h000100);
    check(instr_valid, 1'b0);
    special_mode = 1'b1;
    #1; check(prog_addr, 23'h400100);
    step();
    special_mode = 1'b0;
    step(2);
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    rd(5'h0f);
    check(rd_a_data, 16'h0800);
    step(2);
    give_verdict();
  end
endmodule // dsc_core_programmer_state_tb_top
